// File: rtl/pmcs_pkg.sv
// package: register map, field layout and reset values of the power management block
package pmcs_pkg;
	localparam logic [7:0]  PMCS_ADDR_CTRL_STATUS = 8'hc4;
	localparam logic [7:0]  PMCS_ADDR_IRQ_STATUS  = 8'hc8;
	localparam logic [7:0]  PMCS_ADDR_IRQ_MASK    = 8'hcc;
	localparam logic [7:0]  PMCS_ADDR_CONTROL     = 8'hd0;
	localparam int          PMCS_WAKE_STATUS_BIT  = 15;
	localparam int          PMCS_SCALE_LSB        = 13;
	localparam int          PMCS_SELECT_LSB       = 9;
	localparam int          PMCS_WAKE_ENABLE_BIT  = 8;
	localparam int          PMCS_STATE_LSB        = 0;
	localparam logic [1:0]  PMCS_SCALE_VALUE      = 2'h0;
	localparam logic [3:0]  PMCS_SELECT_RESET     = 4'h0;
	localparam logic [1:0]  PMCS_STATE_D0         = 2'h0;
	localparam logic [1:0]  PMCS_STATE_D3HOT      = 2'h3;
	// interrupt status / mask bits
	localparam int          PMCS_IRQ_WAKE_BIT     = 0;
	localparam int          PMCS_IRQ_STATE_BIT    = 1;
	localparam int          PMCS_IRQ_MAGIC_BIT    = 2;
	localparam int          PMCS_IRQ_W            = 3;
	// control register bits: command bits 18 and 19 mirrored here
	localparam int          PMCS_CMD18_BIT        = 0;
	localparam int          PMCS_CMD19_BIT        = 1;
	localparam logic [1:0]  PMCS_RESP_OKAY        = 2'h0;
	localparam logic [1:0]  PMCS_RESP_SLVERR      = 2'h2;
endpackage

// File: rtl/pmcs_axil_slave.sv
// file: AXI4-Lite slave front end, one write and one read at a time
`timescale 1ns/100ps
module pmcs_axil_slave #(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              clk_en,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   wr_pulse,
	output logic [ADDR_W-1:0]      wr_addr,
	output logic [31:0]            wr_data,
	output logic [3:0]             wr_strb,
	input  wire logic              wr_err,
	output logic [ADDR_W-1:0]      rd_addr,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_err
);
	logic              aw_have_q;
	logic              w_have_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;

	// =========================================================
	// handshakes
	assign s_axi_awready = clk_en && !aw_have_q && !bvalid_q;
	assign s_axi_wready  = clk_en && !w_have_q && !bvalid_q;
	assign s_axi_arready = clk_en && !rvalid_q;
	assign wr_pulse      = clk_en && aw_have_q && w_have_q && !bvalid_q;
	assign wr_addr       = awaddr_q;
	assign wr_data       = wdata_q;
	assign wr_strb       = wstrb_q;
	assign rd_addr       = s_axi_araddr;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= pmcs_pkg::PMCS_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_pulse) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_err ? pmcs_pkg::PMCS_RESP_SLVERR : pmcs_pkg::PMCS_RESP_OKAY;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= pmcs_pkg::PMCS_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_err ? 32'h0 : rd_data;
				rresp_q  <= rd_err ? pmcs_pkg::PMCS_RESP_SLVERR : pmcs_pkg::PMCS_RESP_OKAY;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end
endmodule

// File: rtl/pmcs_power_mgmt.sv
// file: power management control/status register block with wake request output
// Function
// RULE_01 - wake event sets wake status flag bit 15, regardless of wake enable
// RULE_02 - writing one clears wake status and releases wake request; zero no effect
// RULE_03 - report scale field bits 14:13 read-only, always 00b
// RULE_04 - report select field bits 12:9 read/write, reset 0000b, selects nothing
// RULE_05 - wake request enable bit 8, reset zero, gates wake request assertion
// RULE_06 - command bits 18 and 19 both set force magic-packet wake enable on
// RULE_07 - bits 1:0 report power state; writes move to new state; 00 D0..11 D3hot
// RULE_08 - power state returns to D0 automatically when power resumes
// RULE_09 - wake request active while status and enable both one, else released
`timescale 1ns/100ps
module pmcs_power_mgmt #(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              clk_en,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              wake_event,
	input  wire logic              power_resume,
	output logic                   wake_request_n,
	output logic                   magic_wake_enable,
	output logic [1:0]             power_state,
	output logic                   irq
);
	logic                   wr_pulse;
	logic [ADDR_W-1:0]      wr_addr;
	logic [31:0]            wr_data;
	logic [3:0]             wr_strb;
	logic [ADDR_W-1:0]      rd_addr;
	logic [31:0]            rd_data;
	logic                   wr_err;
	logic                   rd_err;

	logic                   wake_status_flag_q;
	logic                   wake_request_enable_q;
	logic [3:0]             report_select_field_q;
	logic [1:0]             power_state_field_q;
	logic [1:0]             cmd_bits_q;
	logic [pmcs_pkg::PMCS_IRQ_W-1:0] irq_status_q;
	logic [pmcs_pkg::PMCS_IRQ_W-1:0] irq_mask_q;
	logic [pmcs_pkg::PMCS_IRQ_W-1:0] irq_events;
	logic                   magic_wake_q;

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		addr_hit = (a == ADDR_W'(off));
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = addr_hit(a, pmcs_pkg::PMCS_ADDR_CTRL_STATUS) ||
			addr_hit(a, pmcs_pkg::PMCS_ADDR_IRQ_STATUS) ||
			addr_hit(a, pmcs_pkg::PMCS_ADDR_IRQ_MASK) ||
			addr_hit(a, pmcs_pkg::PMCS_ADDR_CONTROL);
	endfunction

	// =========================================================
	// bus front end
	pmcs_axil_slave #(
		.ADDR_W (ADDR_W)
	) u_slave (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.clk_en        (clk_en),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_pulse      (wr_pulse),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_err        (wr_err),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_err        (rd_err)
	);

	// =========================================================
	// write decode
	wire wr_cs   = wr_pulse && addr_hit(wr_addr, pmcs_pkg::PMCS_ADDR_CTRL_STATUS);
	wire wr_ists = wr_pulse && addr_hit(wr_addr, pmcs_pkg::PMCS_ADDR_IRQ_STATUS);
	wire wr_imsk = wr_pulse && addr_hit(wr_addr, pmcs_pkg::PMCS_ADDR_IRQ_MASK);
	wire wr_ctl  = wr_pulse && addr_hit(wr_addr, pmcs_pkg::PMCS_ADDR_CONTROL);
	assign wr_err = !mapped(wr_addr);
	assign rd_err = !mapped(rd_addr);

	wire cs_lo = wr_cs && wr_strb[0];
	wire cs_hi = wr_cs && wr_strb[1];
	// wake status clears only on a one in bit 15; a zero leaves it alone
	wire wake_clear = cs_hi && wr_data[pmcs_pkg::PMCS_WAKE_STATUS_BIT]; // [RULE_02]
	wire [1:0] state_wr = wr_data[pmcs_pkg::PMCS_STATE_LSB +: 2];
	// the report select value is kept for software only; nothing but the read mux reads it

	// =========================================================
	// read decode
	wire rd_cs   = addr_hit(rd_addr, pmcs_pkg::PMCS_ADDR_CTRL_STATUS);
	wire rd_ists = addr_hit(rd_addr, pmcs_pkg::PMCS_ADDR_IRQ_STATUS);
	wire rd_imsk = addr_hit(rd_addr, pmcs_pkg::PMCS_ADDR_IRQ_MASK);
	wire rd_ctl  = addr_hit(rd_addr, pmcs_pkg::PMCS_ADDR_CONTROL);

	// =========================================================
	// control/status register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_status_flag_q <= 1'b0;
		end else if (clk_en) begin
			// set wins over a clear in the same cycle
			if (wake_event) begin
				wake_status_flag_q <= 1'b1; // [RULE_01]
			end else if (wake_clear) begin
				wake_status_flag_q <= 1'b0; // [RULE_02]
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_request_enable_q <= 1'b0;
			report_select_field_q <= pmcs_pkg::PMCS_SELECT_RESET;
		end else if (clk_en && cs_hi) begin
			wake_request_enable_q <= wr_data[pmcs_pkg::PMCS_WAKE_ENABLE_BIT]; // [RULE_05]
			report_select_field_q <= wr_data[pmcs_pkg::PMCS_SELECT_LSB +: 4]; // [RULE_04]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_state_field_q <= pmcs_pkg::PMCS_STATE_D0;
		end else if (clk_en) begin
			// resume outranks a simultaneous software write
			if (power_resume) begin
				power_state_field_q <= pmcs_pkg::PMCS_STATE_D0; // [RULE_08]
			end else if (cs_lo) begin
				power_state_field_q <= state_wr; // [RULE_07]
			end
		end
	end

	// =========================================================
	// command bits and magic-packet wake default
	// the default follows the command bits alone, not the wake request enable
	wire cmd_we   = wr_ctl && wr_strb[0];
	wire cmd_both = cmd_bits_q[pmcs_pkg::PMCS_CMD18_BIT] &&
		cmd_bits_q[pmcs_pkg::PMCS_CMD19_BIT]; // [RULE_06]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_bits_q   <= 2'h0;
			magic_wake_q <= 1'b0;
		end else if (clk_en) begin
			if (cmd_we) begin
				cmd_bits_q <= wr_data[1:0];
			end
			magic_wake_q <= cmd_both; // [RULE_06]
		end
	end

	// =========================================================
	// interrupts: sticky status, write one to clear, set wins
	assign irq_events[pmcs_pkg::PMCS_IRQ_WAKE_BIT]  = wake_event;
	assign irq_events[pmcs_pkg::PMCS_IRQ_STATE_BIT] = power_resume ||
		(cs_lo && (state_wr != power_state_field_q));
	assign irq_events[pmcs_pkg::PMCS_IRQ_MAGIC_BIT] = cmd_both && !magic_wake_q;

	// a one written clears its bit; an event in that same cycle keeps it set
	wire [pmcs_pkg::PMCS_IRQ_W-1:0] irq_clear    = (wr_ists && wr_strb[0]) ?
		wr_data[pmcs_pkg::PMCS_IRQ_W-1:0] : '0;
	wire [pmcs_pkg::PMCS_IRQ_W-1:0] irq_status_d = (irq_status_q & ~irq_clear) | irq_events;
	wire                            irq_mask_we  = wr_imsk && wr_strb[0];
	// events that arrive while the clock enable is low are not seen at all

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_q <= '0;
			irq_mask_q   <= '0;
		end else if (clk_en) begin
			irq_status_q <= irq_status_d;
			if (irq_mask_we) begin
				irq_mask_q <= wr_data[pmcs_pkg::PMCS_IRQ_W-1:0];
			end
		end
	end

	// =========================================================
	// read mux
	wire [31:0] cs_word = {16'h0,
		wake_status_flag_q,
		pmcs_pkg::PMCS_SCALE_VALUE, // [RULE_03]
		report_select_field_q,
		wake_request_enable_q,
		6'h0,
		power_state_field_q}; // [RULE_07]

	wire [31:0] ists_word = {{(32-pmcs_pkg::PMCS_IRQ_W){1'b0}}, irq_status_q};
	wire [31:0] imsk_word = {{(32-pmcs_pkg::PMCS_IRQ_W){1'b0}}, irq_mask_q};
	wire [31:0] ctl_word  = {30'h0, cmd_bits_q};

	// unmapped offsets read as zero; the front end flags them with an error response
	assign rd_data = rd_cs   ? cs_word   :
		rd_ists ? ists_word :
		rd_imsk ? imsk_word :
		rd_ctl  ? ctl_word  :
		32'h0;

	// =========================================================
	// outputs
	// wake request is open-drain style, active low
	assign wake_request_n    = !(wake_status_flag_q && wake_request_enable_q); // [RULE_09] [RULE_05]
	assign magic_wake_enable = magic_wake_q;
	assign power_state       = power_state_field_q;
	assign irq               = |(irq_status_q & irq_mask_q);
endmodule

// File: verification/pmcs_wake_model.sv
// wake logic model: raises wake events and power resume toward the register block
`timescale 1ns/100ps
module pmcs_wake_model (
	input  wire logic aclk,
	output logic      wake_event,
	output logic      power_resume,
	input  wire logic wake_request_n
);
	initial begin
		wake_event = 1'h0;
		power_resume = 1'h0;
	end
	// one-cycle event, plus one edge so its effect has landed on return
	task automatic pulse(input logic resume);
		if (resume)
			power_resume <= 1'h1;
		else
			wake_event <= 1'h1;
		@(posedge aclk);
		wake_event <= 1'h0;
		power_resume <= 1'h0;
		@(posedge aclk);
	endtask
endmodule

// File: verification/pmcs_power_mgmt_chk.sv
// concurrent checks on the ports of the power management block
`timescale 1ns/100ps
module pmcs_power_mgmt_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        clk_en,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        wake_event,
	input wire logic        power_resume,
	input wire logic        wake_request_n,
	input wire logic [1:0]  power_state
);
	wire logic wr_act;
	assign wr_act = s_axi_awvalid || s_axi_wvalid;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================
	// bus handshake
	sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
	sequence rd_waiting; s_axi_rvalid && !s_axi_rready; endsequence
	read_answer_a: assert property (rd_taken |=> s_axi_rvalid) else $error("no read answer");
	read_hold_a: assert property (rd_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw taken early");
	read_err_a: assert property (s_axi_rvalid && s_axi_rresp == pmcs_pkg::PMCS_RESP_SLVERR
		|-> s_axi_rdata == 32'h0) else $error("error read has data");
	// ==========================================
	// power state and wake request
	resume_d0_a: assert property (power_resume && clk_en |=> power_state == 2'h0)
		else $error("resume left state");
	state_hold_a: assert property (!power_resume && !$past(wr_act) |=> $stable(power_state))
		else $error("state moved alone");
	wake_hold_a: assert property (!wake_request_n && !wr_act && !$past(wr_act) |=> !wake_request_n)
		else $error("wake request dropped");
	wake_rise_a: assert property ($fell(wake_request_n) |-> $past(wake_event) || $past(wr_act, 2))
		else $error("wake request unprompted");
endmodule

// File: verification/pci_power_mgmt_ctrl_status_test.sv
// self-checking bench for the power management register block
`timescale 1ns/100ps
module pci_power_mgmt_ctrl_status_test;
	localparam logic [7:0] CS = pmcs_pkg::PMCS_ADDR_CTRL_STATUS;
	localparam logic [7:0] IS = pmcs_pkg::PMCS_ADDR_IRQ_STATUS;
	localparam logic [7:0] IM = pmcs_pkg::PMCS_ADDR_IRQ_MASK;
	localparam logic [7:0] CT = pmcs_pkg::PMCS_ADDR_CONTROL;
	logic        aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, wake_event, power_resume, wake_request_n;
	logic        magic_wake_enable, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, power_state, resp;
	logic [3:0]  s_axi_wstrb;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	int          mismatches, num_checks;

	pmcs_power_mgmt i_dut (.*);
	pmcs_wake_model i_wake (.*);

	always #2 aclk = ~aclk;
	// ==========================================
	// bus tasks
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready) break;
			// late ready on purpose, so the slave must hold its answer
			if (s_axi_bvalid) s_axi_bready <= 1'h1;
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_rvalid) s_axi_rready <= 1'h1;
		end
		rd_d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		axi_rd(a);
		check("read data", e, rd_d);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ==========================================
	// tests
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		clk_en = 1'h1;
		s_axi_wstrb = 4'hf;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		rchk(CS, 32'h0);
		check("wake request", 32'h1, wake_request_n);
		axi_wr(CS, 32'hffff_7fff);
		rchk(CS, 32'h0000_1f03);
		for (int s = 0; s < 4; s++) begin
			axi_wr(CS, 32'(s));
			check("state", 32'(s), power_state);
		end
		i_wake.pulse(1'h1);
		check("state", 32'h0, power_state);
		rchk(CS, 32'h0);
		i_wake.pulse(1'h0);
		check("wake request", 32'h1, wake_request_n);
		rchk(CS, 32'h0000_8000);
		axi_wr(CS, 32'h0000_0100);
		check("wake request", 32'h0, wake_request_n);
		axi_wr(CS, 32'h0000_8100);
		check("wake request", 32'h1, wake_request_n);
		rchk(CS, 32'h0000_0100);
		i_wake.pulse(1'h0);
		check("wake request", 32'h0, wake_request_n);
		axi_wr(CS, 32'h0);
		check("wake request", 32'h1, wake_request_n);
		rchk(CS, 32'h0000_8000);
		axi_wr(CT, 32'h1);
		@(posedge aclk);
		check("magic enable", 32'h0, magic_wake_enable);
		axi_wr(CT, 32'h3);
		@(posedge aclk);
		check("magic enable", 32'h1, magic_wake_enable);
		rchk(IS, 32'h7);
		axi_wr(IM, 32'h1);
		check("irq", 32'h1, irq);
		axi_wr(IS, 32'h1);
		check("irq", 32'h0, irq);
		rchk(IS, 32'h6);
		axi_wr(8'hf0, 32'h1);
		check("write resp", 32'(pmcs_pkg::PMCS_RESP_SLVERR), 32'(resp));
		rchk(8'hf0, 32'h0);
		check("read resp", 32'(pmcs_pkg::PMCS_RESP_SLVERR), 32'(resp));
		axi_wr(CS, 32'h0000_1f01);
		check("wake request", 32'h0, wake_request_n);
		// byte lane 0 alone moves the state and leaves bits 15:8 untouched
		s_axi_wstrb <= 4'h1;
		axi_wr(CS, 32'h0000_8002);
		s_axi_wstrb <= 4'hf;
		rchk(CS, 32'h0000_9f02);
		// a resume while the clock enable is low must not reach the state
		clk_en <= 1'h0;
		i_wake.pulse(1'h1);
		clk_en <= 1'h1;
		check("frozen state", 32'h2, power_state);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		check("wake request", 32'h1, wake_request_n);
		rchk(CS, 32'h0);
		rchk(IS, 32'h0);
		check("magic enable", 32'h0, magic_wake_enable);
		complete_run();
	end
	initial begin
		repeat (5000) @(posedge aclk);
		mismatches++;
		complete_run();
	end
endmodule

bind pmcs_power_mgmt pmcs_power_mgmt_chk i_chk (.*);
